// [common/fcsd_pkg.sv]
package fcsd_pkg;
    localparam logic [7:0] OP_RECAL = 8'h07;
    localparam logic [7:0] OP_SENSE_INT = 8'h08;
    localparam logic [7:0] OP_SEEK = 8'h0F;
    localparam logic [7:0] OP_DUMPREG = 8'h0E;
    localparam logic [7:0] OP_SENSE_DRV = 8'h04;
    localparam logic [7:0] INVALID_STATUS = 8'h80;
    // Primary status: seek end bit and head/drive fields
    localparam int SEEK_END_BIT = 5;
    localparam logic [7:0] ST0_SEEK_END = 8'h20;
    localparam int ST3_TRK0_BIT = 4;
    localparam int ST3_WP_BIT = 6;
    localparam int ST3_RDY_BIT = 5;
    localparam int ST3_TS_BIT = 3;
    localparam int DUMP_LEN = 10;
    localparam int STEP_CYCLES_DEF = 16;
    localparam logic [7:0] SRT_HUT_RST = 8'h00;
    localparam logic [7:0] HLT_ND_RST = 8'h00;
    localparam logic [7:0] SC_EOT_RST = 8'h00;
    localparam logic [7:0] LOCK_PERP_RST = 8'h00;
    localparam logic [7:0] CONF_RST = 8'h00;
    localparam logic [7:0] PRECOMP_TRACK_RST = 8'h00;

    typedef struct packed {
        logic [3:0] step_o;
        logic dir_inward;
        logic [1:0] drive;
        logic head_sel;
    } fcsd_drive_s;

    typedef enum logic [5:0] {
        FCSD_IDLE = 6'h01,
        FCSD_ARG1 = 6'h02,
        FCSD_ARG2 = 6'h04,
        FCSD_MOVE = 6'h08,
        FCSD_RES = 6'h10,
        FCSD_WAIT = 6'h20
    } fcsd_state_e;
endpackage

// [core/fcsd_core.sv]
// Notes on behaviour
// (R1) Recalibrate plus drive byte steps head to cylinder zero, then interrupts.
// (R2) Sense interrupt returns primary status then present cylinder.
// (R3) Seek plus drive byte and target cylinder moves head there.
// (R4) Register dump returns four cylinders and stored settings, ten bytes.
// (R5) Sense drive status returns one drive status byte, no head motion.
// (R6) Unknown opcode does nothing and returns one byte 80h.
// (R7) Host writes all command bytes, reads all results before next.
//
// Design decisions made here: the plain strobed port.
module fcsd_core
    import fcsd_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [3:0] track0_i,
    input wire logic [3:0] wprot_i,
    input wire logic [3:0] ready_i,
    input wire logic [7:0] srt_hut_i,
    input wire logic [7:0] hlt_nd_i,
    input wire logic [7:0] sc_eot_i,
    input wire logic [7:0] lock_perp_i,
    input wire logic [7:0] conf_i,
    input wire logic [7:0] precomp_track_i,
    output logic [7:0] rd_data_o,
    output logic res_avail_o,
    output logic busy_o,
    output logic irq_o,
    output fcsd_drive_s drv_o
);
    fcsd_state_e state_r, state_nxt;
    logic [7:0] op_r, op_nxt;
    logic [7:0] sel_r, sel_nxt;
    logic [7:0] tgt_r, tgt_nxt;
    logic [7:0] pcyl_r [4];
    logic [7:0] pcyl_nxt [4];
    logic [7:0] res_r [DUMP_LEN];
    logic [7:0] res_nxt [DUMP_LEN];
    logic [3:0] res_cnt_r, res_cnt_nxt;
    logic [3:0] res_idx_r, res_idx_nxt;
    logic [7:0] st0_r, st0_nxt;
    logic irq_r, irq_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic step_r, step_nxt;
    logic dir_r, dir_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic [1:0] ds;

    function automatic int unsigned arg_count(input logic [7:0] op);
        unique case (op)
            OP_RECAL, OP_SENSE_DRV: arg_count = 1;
            OP_SEEK: arg_count = 2;
            default: arg_count = 0;
        endcase
    endfunction

    assign ds = sel_r[1:0];

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        sel_nxt = sel_r;
        tgt_nxt = tgt_r;
        pcyl_nxt = pcyl_r;
        res_nxt = res_r;
        res_cnt_nxt = res_cnt_r;
        res_idx_nxt = res_idx_r;
        st0_nxt = st0_r;
        irq_nxt = irq_r;
        tmr_nxt = tmr_r;
        step_nxt = 1'b0;
        dir_nxt = dir_r;
        rd_data_nxt = rd_data_r;
        unique case (state_r)
            FCSD_IDLE: begin
                if (wr_i) begin
                    op_nxt = wr_data_i;
                    unique case (wr_data_i)
                        OP_RECAL, OP_SEEK, OP_SENSE_DRV: begin
                            state_nxt = FCSD_ARG1;
                        end
                        // (R2) Sense interrupt result
                        OP_SENSE_INT: begin
                            res_nxt[0] = st0_r;
                            res_nxt[1] = pcyl_r[st0_r[1:0]];
                            res_cnt_nxt = 4'd2;
                            res_idx_nxt = 4'd0;
                            irq_nxt = 1'b0;
                            state_nxt = FCSD_RES;
                        end
                        // (R4) Register dump load
                        OP_DUMPREG: begin
                            for (int i = 0; i < 4; i++) begin
                                res_nxt[i] = pcyl_r[i];
                            end
                            res_nxt[4] = srt_hut_i;
                            res_nxt[5] = hlt_nd_i;
                            res_nxt[6] = sc_eot_i;
                            res_nxt[7] = lock_perp_i;
                            res_nxt[8] = conf_i;
                            res_nxt[9] = precomp_track_i;
                            res_cnt_nxt = 4'(DUMP_LEN);
                            res_idx_nxt = 4'd0;
                            state_nxt = FCSD_RES;
                        end
                        // (R6) Invalid opcode answer
                        default: begin
                            res_nxt[0] = INVALID_STATUS;
                            res_cnt_nxt = 4'd1;
                            res_idx_nxt = 4'd0;
                            state_nxt = FCSD_RES;
                        end
                    endcase
                end
            end
            FCSD_ARG1: begin
                if (wr_i) begin
                    sel_nxt = wr_data_i;
                    if (arg_count(op_r) == 2) begin
                        state_nxt = FCSD_ARG2;
                    end else if (op_r == OP_SENSE_DRV) begin
                        // (R5) Drive status, head untouched
                        res_nxt[0] = {1'b0, wprot_i[wr_data_i[1:0]],
                            ready_i[wr_data_i[1:0]],
                            track0_i[wr_data_i[1:0]], 1'b1,
                            wr_data_i[2:0]};
                        res_cnt_nxt = 4'd1;
                        res_idx_nxt = 4'd0;
                        state_nxt = FCSD_RES;
                    end else begin
                        // (R1) Recalibrate aims at zero
                        tgt_nxt = '0;
                        tmr_nxt = '0;
                        state_nxt = FCSD_MOVE;
                    end
                end
            end
            FCSD_ARG2: begin
                if (wr_i) begin
                    // (R3) Seek target taken
                    tgt_nxt = wr_data_i;
                    tmr_nxt = '0;
                    state_nxt = FCSD_MOVE;
                end
            end
            FCSD_MOVE: begin
                // Steps are paced so the drive mechanics can settle
                if (tmr_r != '0) begin
                    tmr_nxt = tmr_r - 16'd1;
                end else if (pcyl_r[ds] == tgt_r) begin
                    // (R1) Completion raises interrupt
                    st0_nxt = ST0_SEEK_END | {5'h00, sel_r[2:0]};
                    irq_nxt = 1'b1;
                    state_nxt = FCSD_IDLE;
                end else begin
                    // (R3) One step toward target
                    dir_nxt = (tgt_r > pcyl_r[ds]);
                    step_nxt = 1'b1;
                    pcyl_nxt[ds] = (tgt_r > pcyl_r[ds]) ?
                        pcyl_r[ds] + 8'd1 : pcyl_r[ds] - 8'd1;
                    tmr_nxt = 16'(STEP_CYCLES - 1);
                end
            end
            FCSD_RES: begin
                if (rd_i) begin
                    rd_data_nxt = res_r[res_idx_r];
                    res_idx_nxt = res_idx_r + 4'd1;
                    if (res_idx_r + 4'd1 == res_cnt_r) begin
                        state_nxt = FCSD_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = FCSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= FCSD_IDLE;
            op_r <= '0;
            sel_r <= '0;
            tgt_r <= '0;
            pcyl_r <= '{default: 8'h00};
            res_r <= '{default: 8'h00};
            res_cnt_r <= '0;
            res_idx_r <= '0;
            st0_r <= '0;
            irq_r <= 1'b0;
            tmr_r <= '0;
            step_r <= 1'b0;
            dir_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            sel_r <= sel_nxt;
            tgt_r <= tgt_nxt;
            pcyl_r <= pcyl_nxt;
            res_r <= res_nxt;
            res_cnt_r <= res_cnt_nxt;
            res_idx_r <= res_idx_nxt;
            st0_r <= st0_nxt;
            irq_r <= irq_nxt;
            tmr_r <= tmr_nxt;
            step_r <= step_nxt;
            dir_r <= dir_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_o = rd_data_r;
    assign res_avail_o = (state_r == FCSD_RES);
    assign busy_o = (state_r != FCSD_IDLE);
    assign irq_o = irq_r;
    always_comb begin
        drv_o.step_o = '0;
        drv_o.step_o[ds] = step_r;
        drv_o.dir_inward = dir_r;
        drv_o.drive = ds;
        drv_o.head_sel = sel_r[2];
    end
endmodule

// [dv/fcsd_core_props.sv]
module fcsd_core_props
    import fcsd_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic res_avail_o,
    input wire logic busy_o,
    input wire logic irq_o,
    input wire fcsd_drive_s drv_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Opcode only counts when the decoder is idle
    logic op_ok;
    assign op_ok = wr_i && !busy_o;
    property p_irq;
        $rose(irq_o) |-> $past(busy_o) && !res_avail_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without move");
    property p_sint;
        op_ok && wr_data_i == OP_SENSE_INT |=> res_avail_o;
    endproperty
    a_sint: assert property (p_sint) else $error("no status");
    property p_step;
        |drv_o.step_o |-> busy_o && !res_avail_o ##1 drv_o.step_o == 4'h0;
    endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_dump;
        op_ok && wr_data_i == OP_DUMPREG |=> res_avail_o;
    endproperty
    a_dump: assert property (p_dump) else $error("no dump");
    property p_sdrv;
        op_ok && wr_data_i == OP_SENSE_DRV |=> (drv_o.step_o == 4'h0)[*2];
    endproperty
    a_sdrv: assert property (p_sdrv) else $error("head moved");
    property p_inv;
        op_ok && wr_data_i == 8'hFF |=> res_avail_o && drv_o.step_o == 4'h0;
    endproperty
    a_inv: assert property (p_inv) else $error("bad invalid");
endmodule

bind fcsd_core fcsd_core_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .res_avail_o(res_avail_o), .busy_o(busy_o), .irq_o(irq_o), .drv_o(drv_o)
);

// [dv/fcsd_drive_model.sv]
module fcsd_drive_model
    import fcsd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire fcsd_drive_s drv_i,
    output logic [3:0] track0_o
);
    logic [7:0] cyl_r [4];
    logic [7:0] cyl_nxt [4];
    // End stop: outward steps at cylinder zero are lost
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cyl_nxt[i] = cyl_r[i];
            if (drv_i.step_o[i] && drv_i.dir_inward) begin
                cyl_nxt[i] = cyl_r[i] + 8'h01;
            end else if (drv_i.step_o[i] && cyl_r[i] != 8'h00) begin
                cyl_nxt[i] = cyl_r[i] - 8'h01;
            end
            track0_o[i] = (cyl_r[i] == 8'h00);
        end
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cyl_r <= '{default: 8'h00};
        end else begin
            cyl_r <= cyl_nxt;
        end
    end
endmodule

// [dv/tb_floppy_cmd_seek_status_decoder.sv]
module tb_floppy_cmd_seek_status_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import fcsd_pkg::*;
    logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, res_avail_o, busy_o;
    logic irq_o;
    logic [7:0] wr_data_i = 8'h00, rd_data_o;
    logic [3:0] track0_i, wprot_i = 4'h0, ready_i = 4'h0;
    logic [7:0] cfg [6] = '{default: 8'h00};
    fcsd_drive_s drv_o;
    int err_count = 0, checks = 0;
    always #5 mclk_i = ~mclk_i;
    fcsd_core #(.STEP_CYCLES(2)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .track0_i(track0_i),
        .wprot_i(wprot_i), .ready_i(ready_i), .srt_hut_i(cfg[0]),
        .hlt_nd_i(cfg[1]), .sc_eot_i(cfg[2]), .lock_perp_i(cfg[3]),
        .conf_i(cfg[4]), .precomp_track_i(cfg[5]), .rd_data_o(rd_data_o),
        .res_avail_o(res_avail_o), .busy_o(busy_o), .irq_o(irq_o),
        .drv_o(drv_o));
    fcsd_drive_model u_drv (.mclk_i(mclk_i), .rst_i(rst_i), .drv_i(drv_o),
        .track0_o(track0_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] b);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        wr_data_i <= b;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rd_data_o, exp);
    endtask
    // Move a head, wait for the interrupt, then collect its status
    task automatic move(input logic [7:0] op, logic [1:0] d, logic [7:0] c);
        int n;
        n = 0;
        wr(op);
        wr({6'h00, d});
        if (op == OP_SEEK) wr(c);
        while (irq_o !== 1'b1 && n < 500) begin
            @(posedge mclk_i);
            n++;
        end
        chk({7'h00, irq_o}, 8'h01);
        chk({7'h00, track0_i[d]}, {7'h00, c == 8'h00});
        wr(OP_SENSE_INT);
        rd(ST0_SEEK_END | {6'h00, d});
        rd(c);
        chk({7'h00, irq_o}, 8'h00);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        move(OP_SEEK, 2'd1, 8'h03);
        move(OP_SEEK, 2'd3, 8'h05);
        move(OP_RECAL, 2'd1, 8'h00);
        $display("seek and recalibrate done");
        wprot_i <= 4'h4;
        ready_i <= 4'h4;
        wr(OP_SENSE_DRV);
        wr(8'h06);
        rd(8'h7E);
        wr(OP_SENSE_DRV);
        wr(8'h03);
        rd(8'h0B);
        chk({7'h00, track0_i[1]}, 8'h01);
        $display("drive status done");
        cfg <= '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6};
        wr(OP_DUMPREG);
        for (int i = 0; i < 4; i++) rd(i == 3 ? 8'h05 : 8'h00);
        for (int i = 0; i < 6; i++) rd(cfg[i]);
        $display("register dump done");
        foreach (cfg[i]) begin
            wr(i[0] ? 8'hFF : 8'h10 + 8'(i));
            rd(INVALID_STATUS);
        end
        chk({7'h00, busy_o}, 8'h00);
        $display("invalid opcodes done");
        test_done;
    end
endmodule
